// file: bench/tb.sv
// testbench: wishbone register tests of the special serial modes
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t value mismatch", $time); end end
module tb import usoct_pkg::*; ;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic ack, txi, rxi, txo, txoe, rxo, rxoe, sclk, irq, btick;
  logic busy, ph, st, sp, pe, rtry;
  logic [7:0] fd, txd;
  logic [2:0] ev = 3'h0;
  int num_errors = 0, check_count = 0, n;
  // --------------------------------------------------------------
  // clock, design and far side
  // --------------------------------------------------------------
  always #50 clk_i = ~clk_i;
  usoct_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .fe_tx_load_i(ev[2]), .fe_tx_busy_i(busy), .fe_tx_bit_i(1'b0),
    .fe_data_phase_i(ph), .fe_tx_done_i(ev[1]), .fe_tx_nack_i(ev[0]),
    .fe_rx_start_i(st), .fe_rx_stop_end_i(sp), .fe_rx_perr_i(pe),
    .fe_rx_data_i(fd), .tx_data_o(txd), .tx_valid_o(), .tx_retry_o(rtry),
    .rx_line_o(), .bit_tick_o(btick), .sync_rx_bit_o(),
    .sync_rx_valid_o(), .tx_pin_i(txi), .tx_pin_o(txo),
    .tx_pin_oe_o(txoe), .rx_pin_i(rxi), .rx_pin_o(rxo),
    .rx_pin_oe_o(rxoe), .sync_clk_pin_o(sclk), .irq_o(irq));
  usoct_peer peer (.clk_i(clk_i), .tx_pin_o(txo), .tx_pin_oe_o(txoe),
    .rx_pin_o(rxo), .rx_pin_oe_o(rxoe), .tx_pin_i(txi), .rx_pin_i(rxi),
    .busy_o(busy), .phase_o(ph), .start_o(st), .stop_o(sp),
    .perr_o(pe), .data_o(fd));
  // --------------------------------------------------------------
  // bus cycles and waits
  // --------------------------------------------------------------
  task automatic conclude();
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // classic cycle; ack and data taken at the rising edge, released there
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (n == 20) begin num_errors++; conclude(); end
    rd = dat_o;
    cyc <= 1'b0;
  endtask : wb
  // one-cycle frame engine pulse: {load, done, nack}
  task automatic ev_pulse(input logic [2:0] e);
    @(posedge clk_i);
    ev <= e;
    @(posedge clk_i);
    ev <= 3'h0;
  endtask : ev_pulse
  // wait for a number of bit period ticks, bounded
  task automatic ticks(input int k);
    for (int i = 0; i < 200 && k > 0; i++) begin
      @(negedge clk_i);
      if (btick === 1'b1) k--;
    end
    if (k > 0) begin num_errors++; conclude(); end
  endtask : ticks
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, ADR_STAT, 0);
    `CHK(rd[7:0], FLAG_RST)
    wb(0, ADR_BAUD, 0);
    `CHK(rd[15:0], BAUD_RST)
    wb(0, 8'h40, 0);
    `CHK(rd, 32'h0)
    wb(1, ADR_BAUD, 32'h2);
    // timeout of three bit periods after a stop bit
    wb(1, ADR_RTO, 32'h3);
    wb(1, ADR_CTRL, 32'h181);
    peer.frame(0, 8'h5a, 1);
    ticks(1);
    wb(0, ADR_STAT, 0);
    `CHK(rd[F_RTO], 1'b0)
    ticks(4);
    wb(0, ADR_STAT, 0);
    `CHK(rd[F_RTO], 1'b1)
    `CHK(irq, 1'b1)
    wb(1, ADR_STAT, 32'h1);
    `CHK(irq, 1'b0)
    // a start bit halts the count
    peer.frame(0, 8'h00, 1);
    peer.frame(0, 8'h00, 0);
    ticks(6);
    wb(0, ADR_STAT, 0);
    `CHK(rd[F_RTO], 1'b0)
    // card mode: block length zero ends block on the fourth character
    wb(1, ADR_CTRL, 32'h3209);
    wb(1, ADR_STAT, 32'hff);
    repeat (2) peer.frame(0, 8'h11, 1);
    wb(1, ADR_TXD, 32'h33);
    `CHK(txd, 8'h33)
    repeat (3) peer.frame(0, 8'h11, 1);
    wb(0, ADR_STAT, 0);
    `CHK(rd[F_BLK], 1'b0)
    peer.frame(0, 8'h11, 1);
    wb(0, ADR_STAT, 0);
    `CHK(rd[F_BLK], 1'b1)
    `CHK(irq, 1'b1)
    wb(0, ADR_RXD, 0);
    `CHK(rd[7:0], 8'h11)
    wb(1, ADR_STAT, 32'hff);
    // a bad frame never fills the receiver
    peer.frame(1, 8'h22, 1);
    wb(0, ADR_STAT, 0);
    `CHK(rd[F_RXF], 1'b0)
    `CHK(rd[F_PE], 1'b1)
    // card transmit: one retry two bit periods after a nack, then error
    wb(1, ADR_GTPR, 32'h3);
    wb(1, ADR_CTRL, 32'h33209);
    ev_pulse(3'h1);
    n = 0;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (rtry === 1'b1) break;
      if (btick === 1'b1) n++;
    end
    `CHK(n, RETRY_GAP)
    ev_pulse(3'h1);
    wb(0, ADR_STAT, 0);
    `CHK(rd[F_FE], 1'b1)
    // last character: early flag at once, complete only after the guard
    ev_pulse(3'h4);
    ev_pulse(3'h2);
    wb(0, ADR_STAT, 0);
    `CHK(rd[F_TC:F_DBG], 2'h1)
    ticks(4);
    wb(0, ADR_STAT, 0);
    `CHK(rd[F_TC], 1'b1)
    // half duplex keeps both pins released while idle
    wb(1, ADR_CTRL, 32'h4);
    `CHK({txoe, rxoe, txi}, 3'h1)
    // with the pins exchanged only the receive pin carries the line
    wb(1, ADR_CTRL, 32'h44);
    peer.phase(1, 0);
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK({txoe, rxoe, rxi}, 3'h2)
    peer.phase(0, 0);
    // sync master with idle-high clock: quiet outside data bits
    wb(1, ADR_CTRL, 32'h402);
    peer.phase(1, 0);
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_i);
      `CHK(sclk, 1'b1)
    end
    peer.phase(1, 1);
    n = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_i);
      if (sclk === 1'b0) n++;
    end
    `CHK(n > 0, 1'b1)
    peer.phase(0, 0);
    conclude();
  end
endmodule : tb

// file: bench/usoct_peer.sv
// partner model: frame engine events and the pulled-up shared lines
`timescale 1ns/1ps
module usoct_peer (
  input wire logic clk_i,
  input wire logic tx_pin_o,
  input wire logic tx_pin_oe_o,
  input wire logic rx_pin_o,
  input wire logic rx_pin_oe_o,
  output logic tx_pin_i,
  output logic rx_pin_i,
  output logic busy_o,
  output logic phase_o,
  output logic start_o,
  output logic stop_o,
  output logic perr_o,
  output logic [7:0] data_o
);
  // a released line floats high through the pull-up
  assign tx_pin_i = tx_pin_oe_o ? tx_pin_o : 1'b1;
  assign rx_pin_i = rx_pin_oe_o ? rx_pin_o : 1'b1;
  initial begin
    {busy_o, phase_o, start_o, stop_o, perr_o} = 5'h00;
    data_o = 8'h00;
  end
  // one frame: start bit, then stop end with data unless cut short
  task automatic frame(input logic perr, input logic [7:0] d,
                       input logic fin);
    @(posedge clk_i);
    start_o <= 1'b1;
    @(posedge clk_i);
    start_o <= 1'b0;
    stop_o <= fin;
    perr_o <= perr;
    data_o <= d;
    @(posedge clk_i);
    stop_o <= 1'b0;
    perr_o <= 1'b0;
    data_o <= ~d; // data is not held once the stop bit is over
  endtask : frame
  // transmit activity levels
  task automatic phase(input logic b, input logic p);
    @(posedge clk_i);
    busy_o <= b;
    phase_o <= p;
  endtask : phase
endmodule : usoct_peer

// file: rtl/usoct_baud.sv
// module: bit period ticks and smartcard clock divider
`timescale 1ns/1ps
module usoct_baud import usoct_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  usoct_tick_if.gen tk
);
  typedef struct packed {
    logic [15:0] cnt;
    logic btk;
    logic mtk;
    logic [4:0] pc;
    logic cclk;
  } usoct_baud_t;
  usoct_baud_t s_r;
  usoct_baud_t s_nxt;
  logic [15:0] div;
  logic [15:0] half;

  // too small a divisor would never let the half tick fire
  assign div = (tk.divisor < BAUD_MIN) ? BAUD_MIN : tk.divisor;
  assign half = div >> 1;
  assign tk.bit_tick = s_r.btk;
  assign tk.mid_tick = s_r.mtk;
  assign tk.late_half = (s_r.cnt >= half);
  assign tk.card_clk = s_r.cclk;

  // bit counter; the card clock runs at clk / (2 * psv), off when zero
  always_comb begin
    s_nxt = s_r;
    s_nxt.btk = 1'b0;
    s_nxt.mtk = (s_r.cnt == half - 16'h0001);
    if (s_r.cnt >= div - 16'h0001) begin
      s_nxt.cnt = '0;
      s_nxt.btk = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
    if (!tk.card_on || tk.prescaler_value == 5'h00) begin
      s_nxt.pc = '0;
      s_nxt.cclk = 1'b0;
    end else if (s_r.pc >= tk.prescaler_value - 5'h01) begin
      s_nxt.pc = '0;
      s_nxt.cclk = ~s_r.cclk;
    end else begin
      s_nxt.pc = s_r.pc + 5'h01;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : usoct_baud

// file: rtl/usoct_pkg.sv
// package: register map, field positions, reset values for the block
// What this block does
// - sync master drives the bit clock only during data bits
// - clock idle level from clk_polarity_sel, edge from clk_phase_sel
// - sync receive samples data once per bit, no oversampling, no parity
// - half duplex joins tx and rx internally on the transmit pin
// - with pin_exchange set the receive pin is the shared line
// - shared line released when idle; open-drain with a pull-up
// - rx_timeout_on enables a 16-bit timeout counted in bit periods
// - timeout counts from end of stop bit until the next start bit
// - expiry sets rx_timeout_flag, interrupt when rx_timeout_irq_on set
// - card mode adds guard time; bit order and inversion selectable
// - card mode drives a card clock divided by twice prescaler_value
// - card stop lengths 1.5 and 0.5; nack only with 1.5
// - card timeout is 8 bits in etu, restarted after each frame
// - parity error sends nack, retries, then parity_error_flag; no rx_full
// - card nack triggers retransmit after two bits; too many sets frame error
// - done_before_guard_flag at last char end, transfer complete after guard
// - block counter vs block_length_field; zero means four characters
// - block counter reset on transmit data write or rx_on cleared
package usoct_pkg;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_RTO = 8'h04;
  localparam logic [7:0] ADR_GTPR = 8'h08;
  localparam logic [7:0] ADR_BAUD = 8'h0c;
  localparam logic [7:0] ADR_STAT = 8'h10;
  localparam logic [7:0] ADR_TXD = 8'h14;
  localparam logic [7:0] ADR_RXD = 8'h18;
  // control register bit positions
  localparam int C_RX_ON = 0;
  localparam int C_SYNC = 1;
  localparam int C_ONE_WIRE = 2;
  localparam int C_CARD = 3;
  localparam int C_LIN = 4;
  localparam int C_INFRARED = 5;
  localparam int C_SWAP = 6;
  localparam int C_RTO_ON = 7;
  localparam int C_RTO_IRQ = 8;
  localparam int C_BLK_IRQ = 9;
  localparam int C_CLK_POLARITY_SEL = 10;
  localparam int C_CLK_PHASE_SEL = 11;
  localparam int C_STOP_LSB = 12;
  localparam int C_MSB_FIRST = 14;
  localparam int C_INVERT = 15;
  localparam int C_NACK_ON = 16;
  localparam int C_RETRY_LSB = 17;
  // timeout and guard register fields
  localparam int RTO_BLK_LSB = 16;
  localparam int GT_PSV_LSB = 8;
  // status flag positions
  localparam int F_RTO = 0;
  localparam int F_BLK = 1;
  localparam int F_PE = 2;
  localparam int F_FE = 3;
  localparam int F_RXF = 4;
  localparam int F_TXE = 5;
  localparam int F_DBG = 6;
  localparam int F_TC = 7;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] RTO_RST = 32'h0000_0000;
  localparam logic [12:0] GTPR_RST = 13'h0000;
  localparam logic [15:0] BAUD_RST = 16'h0010;
  localparam logic [7:0] FLAG_RST = 8'ha0;
  // line and counting constants
  localparam logic [1:0] STOP_1P5 = 2'h3;
  localparam logic [7:0] BLK_DEFAULT = 8'h04;
  localparam logic [15:0] BAUD_MIN = 16'h0002;
  localparam logic [1:0] RETRY_GAP = 2'h2;
endpackage : usoct_pkg

// file: rtl/usoct_tick_if.sv
// interface: baud generator settings and the ticks it returns
`timescale 1ns/1ps
interface usoct_tick_if;
  logic [15:0] divisor;
  logic [4:0] prescaler_value;
  logic card_on;
  logic bit_tick;
  logic mid_tick;
  logic late_half;
  logic card_clk;
  modport gen (input divisor, prescaler_value, card_on,
               output bit_tick, mid_tick, late_half, card_clk);
  modport user (output divisor, prescaler_value, card_on,
                input bit_tick, mid_tick, late_half, card_clk);
endinterface : usoct_tick_if

// file: rtl/usoct_top.sv
// module: special modes of the serial transceiver with wishbone registers
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module usoct_top import usoct_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fe_tx_load_i,
  input wire logic fe_tx_busy_i,
  input wire logic fe_tx_bit_i,
  input wire logic fe_data_phase_i,
  input wire logic fe_tx_done_i,
  input wire logic fe_tx_nack_i,
  input wire logic fe_rx_start_i,
  input wire logic fe_rx_stop_end_i,
  input wire logic fe_rx_perr_i,
  input wire logic [7:0] fe_rx_data_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic tx_retry_o,
  output logic rx_line_o,
  output logic bit_tick_o,
  output logic sync_rx_bit_o,
  output logic sync_rx_valid_o,
  input wire logic tx_pin_i,
  output logic tx_pin_o,
  output logic tx_pin_oe_o,
  input wire logic rx_pin_i,
  output logic rx_pin_o,
  output logic rx_pin_oe_o,
  output logic sync_clk_pin_o,
  output logic irq_o
);
  // ------------------------------------------------------------------
  // state and helpers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] rto;
    logic [12:0] gtpr;
    logic [15:0] baud;
    logic [7:0] flags;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic [31:0] rdat;
    logic ack;
    logic [2:0] syn;
    logic rx_lvl;
    logic [15:0] tcnt;
    logic trun;
    logic [7:0] blk;
    logic [2:0] rx_try;
    logic [2:0] tx_try;
    logic nack;
    logic [1:0] rdly;
    logic rwait;
    logic retry;
    logic [7:0] gcnt;
    logic grun;
    logic sck;
    logic pclk;
    logic txo;
    logic txoe;
    logic rxo;
    logic rxoe;
    logic srx;
    logic srxv;
  } usoct_st_t;
  usoct_st_t s_r;
  usoct_st_t s_nxt;

  // byte-lane merge of a bus write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // direct or inverse convention applied to a character
  function automatic logic [7:0] conv(input logic [7:0] d,
                                      input logic msb,
                                      input logic inv);
    logic [7:0] r;
    r = d;
    if (msb) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = d[7 - i];
      end
    end
    return inv ? ~r : r;
  endfunction : conv

  usoct_tick_if tk ();

  logic rx_on, sync_on, one_wire, card_on, swap, rto_on;
  logic clk_polarity_sel, clk_phase_sel, msb, inv, nack_on, od;
  logic [1:0] stop_sel;
  logic [2:0] retry_max;
  logic [7:0] blk_len, blk_target, guard;
  logic [15:0] rto_lim;
  logic req, wr, rd, rx_in, good_rx, bad_rx, can_nack;
  logic [7:0] clr, set;
  logic [31:0] mrg;

  // ------------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------------
  assign rx_on = s_r.ctrl[C_RX_ON];
  assign sync_on = s_r.ctrl[C_SYNC];
  assign one_wire = s_r.ctrl[C_ONE_WIRE];
  assign card_on = s_r.ctrl[C_CARD];
  assign swap = s_r.ctrl[C_SWAP];
  assign rto_on = s_r.ctrl[C_RTO_ON];
  assign clk_polarity_sel = s_r.ctrl[C_CLK_POLARITY_SEL];
  assign clk_phase_sel = s_r.ctrl[C_CLK_PHASE_SEL];
  assign stop_sel = s_r.ctrl[C_STOP_LSB +: 2];
  assign msb = s_r.ctrl[C_MSB_FIRST];
  assign inv = s_r.ctrl[C_INVERT];
  assign nack_on = s_r.ctrl[C_NACK_ON];
  assign retry_max = s_r.ctrl[C_RETRY_LSB +: 3];
  assign blk_len = s_r.rto[RTO_BLK_LSB +: 8];
  assign guard = s_r.gtpr[7:0];
  // an open-drain shared line in half duplex and in card mode
  assign od = one_wire | card_on;
  // card mode counts only the low byte, in etu
  assign rto_lim = card_on ? {8'h00, s_r.rto[7:0]} : s_r.rto[15:0];
  assign blk_target = (blk_len == 8'h00) ? BLK_DEFAULT : blk_len;
  // nack only with 1.5 stop bits in card mode
  assign can_nack = card_on & nack_on & (stop_sel == STOP_1P5);

  // ------------------------------------------------------------------
  // bus decode and frame events
  // ------------------------------------------------------------------
  assign req = wb_cyc_i & wb_stb_i & ~s_r.ack;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign good_rx = rx_on & fe_rx_stop_end_i & ~fe_rx_perr_i;
  assign bad_rx = rx_on & fe_rx_stop_end_i & fe_rx_perr_i;
  // the shared line carries receive data too
  assign rx_in = od ? (swap ? rx_pin_i : tx_pin_i)
                    : (swap ? tx_pin_i : rx_pin_i);

  assign tk.divisor = s_r.baud;
  assign tk.prescaler_value = s_r.gtpr[GT_PSV_LSB +: 5];
  assign tk.card_on = card_on;

  usoct_baud u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tk(tk.gen)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    clr = '0;
    set = '0;
    mrg = '0;
    s_nxt.ack = req;
    s_nxt.retry = 1'b0;
    s_nxt.srxv = 1'b0;
    // registered reads; unmapped addresses read zero
    if (s_r.ack) begin
      s_nxt.rdat = '0;
    end else if (wb_adr_i == ADR_CTRL) begin
      s_nxt.rdat = s_r.ctrl;
    end else if (wb_adr_i == ADR_RTO) begin
      s_nxt.rdat = s_r.rto;
    end else if (wb_adr_i == ADR_GTPR) begin
      s_nxt.rdat = {19'h0, s_r.gtpr};
    end else if (wb_adr_i == ADR_BAUD) begin
      s_nxt.rdat = {16'h0, s_r.baud};
    end else if (wb_adr_i == ADR_STAT) begin
      s_nxt.rdat = {24'h0, s_r.flags};
    end else if (wb_adr_i == ADR_RXD) begin
      s_nxt.rdat = {24'h0, s_r.rxd};
    end else begin
      s_nxt.rdat = '0;
    end
    // writes; status is write-one-to-clear
    if (wr) begin
      if (wb_adr_i == ADR_CTRL) begin
        s_nxt.ctrl = merge(s_r.ctrl, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == ADR_RTO) begin
        s_nxt.rto = merge(s_r.rto, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == ADR_GTPR) begin
        mrg = merge({19'h0, s_r.gtpr}, wb_dat_i, wb_sel_i);
        s_nxt.gtpr = mrg[12:0];
      end else if (wb_adr_i == ADR_BAUD) begin
        mrg = merge({16'h0, s_r.baud}, wb_dat_i, wb_sel_i);
        s_nxt.baud = mrg[15:0];
      end else if (wb_adr_i == ADR_STAT && wb_sel_i[0]) begin
        clr = wb_dat_i[7:0];
      end else if (wb_adr_i == ADR_TXD && wb_sel_i[0]) begin
        s_nxt.txd = conv(wb_dat_i[7:0], msb, inv);
        clr[F_TXE] = 1'b1;
        s_nxt.blk = '0;
      end
    end
    if (rd && wb_adr_i == ADR_RXD) begin
      clr[F_RXF] = 1'b1;
    end
    // three-stage sync; a level counts once stages two and three agree
    s_nxt.syn = {s_r.syn[1:0], rx_in};
    if (s_r.syn[1] == s_r.syn[2]) begin
      s_nxt.rx_lvl = s_r.syn[2];
    end
    // receiver timeout, one step per bit period
    if (fe_rx_start_i) begin
      s_nxt.trun = 1'b0;
      s_nxt.tcnt = '0;
    end else if (rx_on & fe_rx_stop_end_i) begin
      s_nxt.trun = rto_on;
      s_nxt.tcnt = '0;
    end else if (s_r.trun & tk.bit_tick) begin
      s_nxt.tcnt = s_r.tcnt + 16'h0001;
      if (s_r.tcnt + 16'h0001 == rto_lim) begin
        set[F_RTO] = 1'b1;
        s_nxt.trun = 1'b0;
      end
    end
    if (!rto_on) begin
      s_nxt.trun = 1'b0;
    end
    // good frames fill the data register and, in card mode, count the block
    if (good_rx) begin
      s_nxt.rxd = conv(fe_rx_data_i, msb, inv);
      set[F_RXF] = 1'b1;
      s_nxt.rx_try = '0;
      if (card_on) begin
        s_nxt.blk = s_r.blk + 8'h01;
        if (s_r.blk + 8'h01 == blk_target) begin
          set[F_BLK] = 1'b1;
        end
      end
    end
    // bad frames never reach the data register
    if (bad_rx) begin
      if (can_nack && s_r.rx_try < retry_max) begin
        s_nxt.nack = 1'b1;
        s_nxt.rx_try = s_r.rx_try + 3'h1;
      end else begin
        set[F_PE] = 1'b1;
        s_nxt.rx_try = '0;
      end
    end else if (s_r.nack & tk.bit_tick) begin
      s_nxt.nack = 1'b0; // nack held low until the next bit period tick
    end
    // a data write must win over a frame counted in the same cycle
    if (!rx_on || (wr && wb_adr_i == ADR_TXD && wb_sel_i[0])) begin
      s_nxt.blk = '0;
    end
    // transmit side: load, nack retry and guard time
    if (fe_tx_load_i) begin
      set[F_TXE] = 1'b1;
    end
    if (card_on & fe_tx_nack_i) begin
      if (s_r.tx_try < retry_max) begin
        s_nxt.tx_try = s_r.tx_try + 3'h1;
        s_nxt.rwait = 1'b1;
        s_nxt.rdly = '0;
      end else begin
        set[F_FE] = 1'b1;
        s_nxt.tx_try = '0;
      end
    end else if (s_r.rwait & tk.bit_tick) begin
      if (s_r.rdly == RETRY_GAP - 2'h1) begin
        s_nxt.rwait = 1'b0;
        s_nxt.retry = 1'b1;
      end else begin
        s_nxt.rdly = s_r.rdly + 2'h1;
      end
    end
    if (fe_tx_done_i) begin
      s_nxt.tx_try = '0;
      if (s_r.flags[F_TXE]) begin
        if (!card_on || guard == 8'h00) begin
          set[F_TC] = 1'b1;
        end else begin
          s_nxt.grun = 1'b1;
          s_nxt.gcnt = '0;
        end
        set[F_DBG] = card_on;
      end
    end else if (s_r.grun & tk.bit_tick) begin
      s_nxt.gcnt = s_r.gcnt + 8'h01;
      if (s_r.gcnt + 8'h01 == guard) begin
        s_nxt.grun = 1'b0;
        set[F_TC] = 1'b1;
      end
    end
    if (fe_tx_load_i) begin
      clr[F_TC] = 1'b1;
      clr[F_DBG] = 1'b1;
    end
    // a hardware set in the same cycle as a clear wins
    s_nxt.flags = (s_r.flags & ~clr) | set;
    // sync clock pulses only during data bits, idle at the polarity
    s_nxt.sck = clk_polarity_sel ^ (sync_on & fe_data_phase_i
                        & (clk_phase_sel ? ~tk.late_half : tk.late_half));
    s_nxt.pclk = card_on ? tk.card_clk : s_nxt.sck;
    // one sample per bit at mid bit, which is the chosen clock edge
    if (sync_on & rx_on & fe_data_phase_i & tk.mid_tick) begin
      s_nxt.srx = s_r.rx_lvl;
      s_nxt.srxv = 1'b1;
    end
    // pins: open drain pulls low only for zeros and nack
    s_nxt.txo = 1'b1;
    s_nxt.rxo = 1'b1;
    s_nxt.txoe = 1'b0;
    s_nxt.rxoe = 1'b0;
    if (od) begin
      if ((fe_tx_busy_i & ~fe_tx_bit_i) | s_r.nack) begin
        s_nxt.txo = 1'b0;
        s_nxt.rxo = 1'b0;
        s_nxt.txoe = ~swap;
        s_nxt.rxoe = swap;
      end
    end else begin
      s_nxt.txo = fe_tx_busy_i ? fe_tx_bit_i : 1'b1;
      s_nxt.rxo = s_nxt.txo;
      s_nxt.txoe = ~swap;
      s_nxt.rxoe = swap;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RST;
      s_r.rto <= RTO_RST;
      s_r.gtpr <= GTPR_RST;
      s_r.baud <= BAUD_RST;
      s_r.flags <= FLAG_RST;
      s_r.syn <= 3'h7;
      s_r.rx_lvl <= 1'b1;
      s_r.txo <= 1'b1;
      s_r.rxo <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;
  assign tx_data_o = s_r.txd;
  assign tx_valid_o = ~s_r.flags[F_TXE];
  assign tx_retry_o = s_r.retry;
  assign rx_line_o = s_r.rx_lvl;
  assign bit_tick_o = tk.bit_tick;
  assign sync_rx_bit_o = s_r.srx;
  assign sync_rx_valid_o = s_r.srxv;
  assign tx_pin_o = s_r.txo;
  assign tx_pin_oe_o = s_r.txoe;
  assign rx_pin_o = s_r.rxo;
  assign rx_pin_oe_o = s_r.rxoe;
  assign sync_clk_pin_o = s_r.pclk;
  // interrupt level from enabled sticky flags
  assign irq_o = (s_r.flags[F_RTO] & s_r.ctrl[C_RTO_IRQ])
               | (s_r.flags[F_BLK] & s_r.ctrl[C_BLK_IRQ]);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_clk_idle;
    sync_on && !card_on && !fe_data_phase_i |=>
      sync_clk_pin_o == $past(clk_polarity_sel);
  endproperty
  a_clk_idle: assert property (p_clk_idle)
    else $error("sync clock not at idle level outside data");

  property p_line_free;
    one_wire && !swap && !fe_tx_busy_i && !s_r.nack && !bad_rx
      |=> !tx_pin_oe_o;
  endproperty
  a_line_free: assert property (p_line_free)
    else $error("shared line driven while idle");

  property p_swap;
    one_wire && swap |=> !tx_pin_oe_o;
  endproperty
  a_swap: assert property (p_swap)
    else $error("transmit pin driven after pin exchange");

  property p_rto_flag;
    s_r.trun && tk.bit_tick && !fe_rx_start_i && !fe_rx_stop_end_i
      && rto_on && s_r.tcnt + 16'h0001 == rto_lim |=> s_r.flags[F_RTO];
  endproperty
  a_rto_flag: assert property (p_rto_flag)
    else $error("timeout flag missing on expiry");

  property p_rto_stop;
    fe_rx_start_i |=> !s_r.trun && s_r.tcnt == 16'h0000;
  endproperty
  a_rto_stop: assert property (p_rto_stop)
    else $error("timeout still running after start bit");

  property p_blk_rst;
    wr && wb_adr_i == ADR_TXD && wb_sel_i[0] |=> s_r.blk == 8'h00;
  endproperty
  a_blk_rst: assert property (p_blk_rst)
    else $error("block counter not reset by data write");

  property p_bad_no_full;
    bad_rx && !s_r.flags[F_RXF] |=> !s_r.flags[F_RXF];
  endproperty
  a_bad_no_full: assert property (p_bad_no_full)
    else $error("erroneous frame set receive full");

  property p_dbg;
    card_on && fe_tx_done_i && s_r.flags[F_TXE] |=> s_r.flags[F_DBG];
  endproperty
  a_dbg: assert property (p_dbg)
    else $error("done before guard flag not set");

  property p_retry_gap;
    card_on && fe_tx_nack_i && s_r.tx_try < retry_max
      |=> !tx_retry_o [*2];
  endproperty
  a_retry_gap: assert property (p_retry_gap)
    else $error("retry came without the two bit delay");

  c_rto: cover property (set[F_RTO]);
  c_blk: cover property (set[F_BLK]);
  c_retry: cover property (tx_retry_o);
  c_srx: cover property (sync_rx_valid_o);
endmodule : usoct_top
